// ==== gpr_pkg.sv ====
package gpr_pkg;
  localparam int num_ports = 6;
  localparam int port_w = 8;
  localparam int addr_w = 8;
  // Printed offsets are all multiples of four: byte address = 4 x index
  localparam logic [5:0] idx_a_data = 6'h00;
  localparam logic [5:0] idx_a_dir = 6'h01;
  localparam logic [5:0] idx_a_opt = 6'h02;
  localparam logic [5:0] idx_b_data = 6'h03;
  localparam logic [5:0] idx_b_dir = 6'h04;
  localparam logic [5:0] idx_unused = 6'h05;
  localparam logic [5:0] idx_c_data = 6'h06;
  localparam logic [5:0] idx_c_dir = 6'h07;
  localparam logic [5:0] idx_c_opt = 6'h08;
  localparam logic [5:0] idx_d_data = 6'h09;
  localparam logic [5:0] idx_d_dir = 6'h0a;
  localparam logic [5:0] idx_d_opt = 6'h0b;
  localparam logic [5:0] idx_e_data = 6'h0c;
  localparam logic [5:0] idx_e_dir = 6'h0d;
  localparam logic [5:0] idx_e_opt = 6'h0e;
  localparam logic [5:0] idx_f_data = 6'h0f;
  localparam logic [5:0] idx_f_dir = 6'h10;
  localparam logic [5:0] idx_irq_status = 6'h11;
  localparam logic [5:0] idx_irq_enable = 6'h12;
  localparam logic [5:0] idx_irq_clear = 6'h13;
  localparam logic [7:0] reg_reset = 8'h00;
  localparam logic [2:0] irq_reset = 3'h0;
  // Per-port option bit implementation masks; 1 = bit exists
  localparam logic [7:0] opt_mask_a = 8'hff;
  localparam logic [7:0] opt_mask_c = 8'hff;
  localparam logic [7:0] opt_mask_d = 8'hff;
  localparam logic [7:0] opt_mask_e = 8'hff;
  // Status bit positions: one per interrupt-capable port
  localparam int irq_bit_a = 0;
  localparam int irq_bit_c = 1;
  localparam int irq_bit_d = 2;
  localparam int irq_w = 3;
endpackage : gpr_pkg

// ==== gpr_regs.sv ====
`timescale 1ns/1ps
module gpr_regs
  import gpr_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpr_pkg::addr_w-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [gpr_pkg::port_w-1:0] pin_in [gpr_pkg::num_ports],
  output logic [gpr_pkg::port_w-1:0] pin_out [gpr_pkg::num_ports],
  output logic [gpr_pkg::port_w-1:0] pin_oe_n [gpr_pkg::num_ports],
  output logic irq
);
  import gpr_pkg::*;

  // ****************************************
  // Register storage
  // ****************************************
  logic [port_w-1:0] port_pin_data [num_ports];
  logic [port_w-1:0] port_pin_direction [num_ports];
  logic [port_w-1:0] port_pin_option [num_ports];
  logic [port_w-1:0] in_prev [num_ports];
  logic [irq_w-1:0] irq_status;
  logic [irq_w-1:0] irq_enable;

  logic wr_en;
  logic [5:0] idx;
  logic [port_w-1:0] wbyte;
  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign idx = paddr[7:2];
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Kind of register: 0 data, 1 direction, 2 option, 3 none
  function automatic logic [1:0] reg_kind(input logic [5:0] i);
    case (i)
      idx_a_data, idx_b_data, idx_c_data, idx_d_data, idx_e_data,
        idx_f_data: reg_kind = 2'h0;
      idx_a_dir, idx_b_dir, idx_c_dir, idx_d_dir, idx_e_dir,
        idx_f_dir: reg_kind = 2'h1;
      idx_a_opt, idx_c_opt, idx_d_opt, idx_e_opt: reg_kind = 2'h2;
      default: reg_kind = 2'h3;
    endcase
  endfunction : reg_kind

  function automatic int reg_port(input logic [5:0] i);
    case (i)
      idx_a_data, idx_a_dir, idx_a_opt: reg_port = 0;
      idx_b_data, idx_b_dir: reg_port = 1;
      idx_c_data, idx_c_dir, idx_c_opt: reg_port = 2;
      idx_d_data, idx_d_dir, idx_d_opt: reg_port = 3;
      idx_e_data, idx_e_dir, idx_e_opt: reg_port = 4;
      default: reg_port = 5;
    endcase
  endfunction : reg_port

  function automatic logic [port_w-1:0] opt_mask(input int p);
    case (p)
      0: opt_mask = opt_mask_a;
      2: opt_mask = opt_mask_c;
      3: opt_mask = opt_mask_d;
      4: opt_mask = opt_mask_e;
      default: opt_mask = reg_reset;
    endcase
  endfunction : opt_mask

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int p = 0; p < num_ports; p++)
      begin
        port_pin_data[p] <= reg_reset;
        port_pin_direction[p] <= reg_reset;
        port_pin_option[p] <= reg_reset;
      end
    end
    else if (wr_en)
    begin
      // Index 5 and above the map fall to kind 3 and are dropped
      case (reg_kind(idx))
        2'h0: port_pin_data[reg_port(idx)] <= wbyte;
        2'h1: port_pin_direction[reg_port(idx)] <= wbyte;
        2'h2: port_pin_option[reg_port(idx)] <=
          wbyte & opt_mask(reg_port(idx));
        default: ;
      endcase
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  // Open drain only ever pulls low; a high bit releases the pin
  always_comb
  begin
    for (int p = 0; p < num_ports; p++)
    begin
      for (int b = 0; b < port_w; b++)
      begin
        pin_out[p][b] = port_pin_data[p][b];
        if (!port_pin_direction[p][b])
          pin_oe_n[p][b] = 1'b1;
        else if (port_pin_option[p][b])
          pin_oe_n[p][b] = 1'b0;
        else
          pin_oe_n[p][b] = port_pin_data[p][b];
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  function automatic logic [port_w-1:0] data_view(input int p);
    // Input pins show the pin, outputs the stored level
    data_view = (pin_in[p] & ~port_pin_direction[p]) |
      (port_pin_data[p] & port_pin_direction[p]);
  endfunction : data_view

  logic [port_w-1:0] rbyte;
  always_comb
  begin
    rbyte = reg_reset;
    case (reg_kind(idx))
      2'h0: rbyte = data_view(reg_port(idx));
      2'h1: rbyte = port_pin_direction[reg_port(idx)];
      2'h2: rbyte = port_pin_option[reg_port(idx)];
      default:
      begin
        if (idx == idx_irq_status)
          rbyte = {5'h00, irq_status};
        else if (idx == idx_irq_enable)
          rbyte = {5'h00, irq_enable};
        else
          rbyte = reg_reset;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= {24'h000000, rbyte};
  end

  // ****************************************
  // Interrupts
  // ****************************************
  // Any change on an option-enabled input pin of port a, c or d is an event; edge
  // polarity selection lives elsewhere in the chip
  function automatic logic port_event(input int p);
    port_event = |((pin_in[p] ^ in_prev[p]) & ~port_pin_direction[p] &
      port_pin_option[p]);
  endfunction : port_event

  logic [irq_w-1:0] events;
  logic [irq_w-1:0] clr;
  assign events = {port_event(3), port_event(2), port_event(0)};
  assign clr = (wr_en && idx == idx_irq_clear) ? wbyte[irq_w-1:0]
    : irq_reset;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int p = 0; p < num_ports; p++)
        in_prev[p] <= reg_reset;
    end
    else
    begin
      for (int p = 0; p < num_ports; p++)
        in_prev[p] <= pin_in[p];
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      irq_status <= irq_reset;
    else
      irq_status <= (irq_status & ~clr) | events;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      irq_enable <= irq_reset;
    else if (wr_en && idx == idx_irq_enable)
      irq_enable <= wbyte[irq_w-1:0];
  end

  assign irq = |(irq_status & irq_enable);

  // ****************************************
  // Checks
  // ****************************************
  // Setup phase of a read from index i
  sequence s_rd_setup(logic [5:0] i);
    psel && !penable && !pwrite && idx == i;
  endsequence

  // Access phase of a write to index i
  sequence s_wr_access(logic [5:0] i);
    wr_en && idx == i;
  endsequence

  // Reset held over two edges, so the first edge has applied it
  sequence s_in_reset;
    !nrst ##1 !nrst;
  endsequence

  a_data_stored: assert property (
    @(posedge clock) disable iff (!nrst)
    s_wr_access(idx_c_data) |=> port_pin_data[2] == $past(wbyte))
    else $error("data write not stored");
  a_data_a_stored: assert property (
    @(posedge clock) disable iff (!nrst)
    s_wr_access(idx_a_data) |=> port_pin_data[0] == $past(wbyte))
    else $error("port a data write not stored");
  a_data_f_stored: assert property (
    @(posedge clock) disable iff (!nrst)
    s_wr_access(idx_f_data) |=> port_pin_data[5] == $past(wbyte))
    else $error("port f data write not stored");
  a_input_kept: assert property (
    @(posedge clock) disable iff (!nrst)
    s_wr_access(idx_d_data) ##0 (port_pin_direction[3] == 8'h00) |=>
    port_pin_data[3] == $past(wbyte))
    else $error("data write lost while pins are inputs");

  a_input_read: assert property (
    @(posedge clock) disable iff (!nrst)
    s_rd_setup(idx_b_data) ##0 (port_pin_direction[1] == 8'h00) |=>
    prdata[7:0] == $past(pin_in[1]))
    else $error("input pin level not read");
  a_input_read_a: assert property (
    @(posedge clock) disable iff (!nrst)
    s_rd_setup(idx_a_data) ##0 (port_pin_direction[0] == 8'h00) |=>
    prdata[7:0] == $past(pin_in[0]))
    else $error("port a input level not read");
  a_input_read_f: assert property (
    @(posedge clock) disable iff (!nrst)
    s_rd_setup(idx_f_data) ##0 (port_pin_direction[5] == 8'h00) |=>
    prdata[7:0] == $past(pin_in[5]))
    else $error("port f input level not read");
  a_output_read: assert property (
    @(posedge clock) disable iff (!nrst)
    s_rd_setup(idx_a_data) ##0 (port_pin_direction[0] == 8'hff) |=>
    prdata[7:0] == $past(port_pin_data[0]))
    else $error("output pins do not read stored data");

  a_dir_float: assert property (
    @(posedge clock) disable iff (!nrst)
    (port_pin_direction[0] == 8'h00) |-> pin_oe_n[0] == 8'hff)
    else $error("input pin driven");
  a_dir_float_f: assert property (
    @(posedge clock) disable iff (!nrst)
    (port_pin_direction[5] == 8'h00) |-> pin_oe_n[5] == 8'hff)
    else $error("port f input pin driven");
  a_dir_update: assert property (
    @(posedge clock) disable iff (!nrst)
    s_wr_access(idx_a_dir) |=> port_pin_direction[0] == $past(wbyte))
    else $error("direction not updated");
  a_dir_update_e: assert property (
    @(posedge clock) disable iff (!nrst)
    s_wr_access(idx_e_dir) |=> port_pin_direction[4] == $past(wbyte))
    else $error("port e direction not updated");
  a_dir_readback: assert property (
    @(posedge clock) disable iff (!nrst)
    s_rd_setup(idx_c_dir) |=> prdata[7:0] == $past(port_pin_direction[2]))
    else $error("direction read back wrong");

  a_irq_event: assert property (
    @(posedge clock) disable iff (!nrst)
    events[irq_bit_a] |=> irq_status[irq_bit_a])
    else $error("interrupt event lost");
  a_irq_c_event: assert property (
    @(posedge clock) disable iff (!nrst)
    events[irq_bit_c] |=> irq_status[irq_bit_c])
    else $error("port c interrupt event lost");
  a_irq_d_event: assert property (
    @(posedge clock) disable iff (!nrst)
    events[irq_bit_d] |=> irq_status[irq_bit_d])
    else $error("port d interrupt event lost");
  a_irq_sticky: assert property (
    @(posedge clock) disable iff (!nrst)
    (irq_status[irq_bit_a] && !clr[irq_bit_a]) |=> irq_status[irq_bit_a])
    else $error("status bit dropped without a clear");
  a_irq_clear: assert property (
    @(posedge clock) disable iff (!nrst)
    (clr[irq_bit_c] && !events[irq_bit_c]) |=> !irq_status[irq_bit_c])
    else $error("status bit not cleared");
  a_float_no_irq: assert property (
    @(posedge clock) disable iff (!nrst)
    (port_pin_option[3] == 8'h00 && !irq_status[irq_bit_d]) |=>
    !irq_status[irq_bit_d])
    else $error("plain floating input raised an event");

  a_push_pull: assert property (
    @(posedge clock) disable iff (!nrst)
    (port_pin_direction[2][0] && port_pin_option[2][0]) |->
    !pin_oe_n[2][0])
    else $error("push-pull not driving");
  a_push_pull_e: assert property (
    @(posedge clock) disable iff (!nrst)
    (port_pin_direction[4][7] && port_pin_option[4][7]) |->
    !pin_oe_n[4][7])
    else $error("port e push-pull not driving");
  a_drain_low: assert property (
    @(posedge clock) disable iff (!nrst)
    (port_pin_direction[0][0] && !port_pin_option[0][0] &&
     !port_pin_data[0][0]) |-> !pin_oe_n[0][0])
    else $error("open drain not pulling low");
  a_drain_release: assert property (
    @(posedge clock) disable iff (!nrst)
    (port_pin_direction[3][7] && !port_pin_option[3][7] &&
     port_pin_data[3][7]) |-> pin_oe_n[3][7])
    else $error("open drain drove high");

  a_open_drain: assert property (
    @(posedge clock) disable iff (!nrst)
    (port_pin_direction[1][0] && port_pin_data[1][0]) |->
    pin_oe_n[1][0])
    else $error("port without option drove high");
  a_no_option: assert property (
    @(posedge clock) disable iff (!nrst)
    port_pin_option[5] == 8'h00 && port_pin_option[1] == 8'h00)
    else $error("option set on port without one");

  a_opt_masked: assert property (
    @(posedge clock) disable iff (!nrst)
    s_wr_access(idx_e_opt) |=>
    port_pin_option[4] == $past(wbyte & opt_mask_e))
    else $error("option write kept a missing bit");
  a_f_dir_only: assert property (
    @(posedge clock) disable iff (!nrst)
    (port_pin_direction[5][3] && !port_pin_data[5][3]) |->
    !pin_oe_n[5][3])
    else $error("direction alone did not drive the pin");

  a_reset_regs: assert property (
    @(posedge clock)
    s_in_reset |-> port_pin_data[0] == reg_reset &&
    port_pin_direction[2] == reg_reset && port_pin_option[4] == reg_reset)
    else $error("register not cleared by reset");
  a_reset_pins: assert property (
    @(posedge clock)
    s_in_reset |-> pin_oe_n[3] == 8'hff && pin_out[1] == reg_reset)
    else $error("pin not floating in reset");
  a_reset_irq: assert property (
    @(posedge clock)
    s_in_reset |-> !irq && irq_status == irq_reset)
    else $error("interrupt active in reset");

  a_pin_follows: assert property (
    @(posedge clock) disable iff (!nrst)
    pin_out[3] == port_pin_data[3])
    else $error("pin level differs from data register");
  a_pin_follows_f: assert property (
    @(posedge clock) disable iff (!nrst)
    pin_out[5] == port_pin_data[5])
    else $error("port f pin level differs from data register");

  a_unused_zero: assert property (
    @(posedge clock) disable iff (!nrst)
    s_rd_setup(idx_unused) |=> prdata == 32'h00000000)
    else $error("unused offset not zero");
  a_unused_ignored: assert property (
    @(posedge clock) disable iff (!nrst)
    s_wr_access(idx_unused) |=>
    $stable(port_pin_direction[1]) && $stable(port_pin_data[2]))
    else $error("write to unused offset changed a register");

  a_irq_level: assert property (
    @(posedge clock) disable iff (!nrst)
    (irq_status[irq_bit_c] && irq_enable[irq_bit_c]) |-> irq)
    else $error("enabled status bit did not raise irq");
  a_rdata_hold: assert property (
    @(posedge clock) disable iff (!nrst)
    (psel && penable) |=> $stable(prdata))
    else $error("read data changed outside a read setup");
endmodule : gpr_regs

// ==== gpr_pin_model.sv ====
`timescale 1ns/1ps
module gpr_pin_model
  import gpr_pkg::*;
(
  input wire logic [gpr_pkg::port_w-1:0] pin_out [gpr_pkg::num_ports],
  input wire logic [gpr_pkg::port_w-1:0] pin_oe_n [gpr_pkg::num_ports],
  input wire logic [gpr_pkg::port_w-1:0] ext_level [gpr_pkg::num_ports],
  output logic [gpr_pkg::port_w-1:0] pin_level [gpr_pkg::num_ports]
);
  // ************
  // Pin wires
  // ************
  always_comb
  begin
    for (int p = 0; p < num_ports; p++)
    begin
      // Released bits show the outside driver, never a stale block value
      pin_level[p] = (pin_out[p] & ~pin_oe_n[p]) |
        (ext_level[p] & pin_oe_n[p]);
    end
  end
endmodule : gpr_pin_model

// ==== gpio_port_registers_tb_top.sv ====
`timescale 1ns/1ps
module gpio_port_registers_tb_top;
  import gpr_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [addr_w-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic irq;
  logic [port_w-1:0] pin_in [num_ports];
  logic [port_w-1:0] pin_out [num_ports];
  logic [port_w-1:0] pin_oe_n [num_ports];
  logic [port_w-1:0] ext [num_ports];
  logic [7:0] rd;
  int mismatches = 0;
  int num_checks = 0;
  always #25 clock = ~clock;
  gpr_regs dut_u (.clock(clock), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq));
  gpr_pin_model pins_u (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_level(ext), .pin_level(pin_in));
  // ************
  // Shared tasks
  // ************
  task give_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    pstrb <= 4'hf;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      mismatches++;
      give_verdict;
    end
    rd = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdchk(input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask : rdchk
  // ************
  // Scenarios
  // ************
  task t_reset;
    for (int i = 0; i <= 16; i++)
      rdchk(i[5:0], reg_reset);
    for (int p = 0; p < num_ports; p++)
      chk(pin_oe_n[p], 8'hff);
    $display("t_reset done");
  endtask : t_reset
  task t_data;
    ext[0] <= 8'ha5;
    apb(1'b1, idx_a_data, 8'h3c);
    rdchk(idx_a_data, 8'ha5);
    apb(1'b1, idx_a_dir, 8'h0f);
    rdchk(idx_a_dir, 8'h0f);
    rdchk(idx_a_data, 8'hac);
    #1 chk(pin_out[0], 8'h3c);
    chk(pin_oe_n[0], 8'hfc);
    $display("t_data done");
  endtask : t_data
  task t_opt;
    apb(1'b1, idx_a_opt, 8'hff);
    #1 chk(pin_oe_n[0], 8'hf0);
    apb(1'b1, idx_b_dir, 8'hff);
    apb(1'b1, idx_b_data, 8'h81);
    #1 chk(pin_oe_n[1], 8'h81);
    apb(1'b1, idx_f_dir, 8'h80);
    #1 chk(pin_oe_n[5], 8'h7f);
    apb(1'b1, idx_unused, 8'hff);
    rdchk(idx_unused, 8'h00);
    rdchk(idx_a_opt, 8'hff);
    $display("t_opt done");
  endtask : t_opt
  task t_irq;
    apb(1'b1, idx_irq_enable, 8'h02);
    apb(1'b1, idx_c_opt, 8'hff);
    ext[2] <= 8'h01;
    repeat (3) @(posedge clock);
    #1 chk({7'h0, irq}, 8'h01);
    rdchk(idx_irq_status, 8'h02);
    apb(1'b1, idx_irq_clear, 8'h07);
    #1 chk({7'h0, irq}, 8'h00);
    // Leaving output mode moves the pins too, so clear after the toggle
    apb(1'b1, idx_a_dir, 8'h00);
    ext[0] <= 8'h5a;
    repeat (3) @(posedge clock);
    rdchk(idx_irq_status, 8'h01);
    chk({7'h0, irq}, 8'h00);
    apb(1'b1, idx_irq_clear, 8'h07);
    apb(1'b1, idx_e_opt, 8'hff);
    ext[4] <= 8'hff;
    repeat (3) @(posedge clock);
    rdchk(idx_irq_status, 8'h00);
    $display("t_irq done");
  endtask : t_irq
  // ************
  // Main sequence
  // ************
  initial
  begin
    for (int p = 0; p < num_ports; p++)
      ext[p] = 8'h00;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    t_reset;
    t_data;
    t_opt;
    t_irq;
    give_verdict;
  end
  initial
  begin
    repeat (5000) @(posedge clock);
    mismatches++;
    give_verdict;
  end
endmodule : gpio_port_registers_tb_top
